/* File: verilog/ivw_core.sv */
// ivw_core: input over/under-voltage warning thresholds, warning flags,
// active-low alert and turn-on delay sequencer.
// assumes the command decoder, vin measurement and start condition are
// synchronous to clk_sys_i; the status clear comes from that decoder too.
// Behaviour
// - vin above the over-voltage threshold sets the ov flag and asserts alert.
// - over-voltage threshold is unsigned, half a volt per code step.
// - over-voltage threshold resets to code 0x20, that is sixteen volts.
// - vin below the under-voltage threshold sets the uv flag and asserts alert.
// - under-voltage threshold is unsigned, quarter volt per code step.
// - under-voltage threshold resets to code 0x1C, that is seven volts.
// - after a start condition wait turn-on delay milliseconds, then start ramping.
`timescale 1ns/10ps
`default_nettype none

module ivw_core
  import ivw_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire ivw_req_t    req_i,
  output logic [15:0]      rdata_o,
  input  wire logic [15:0] vin_mv_i,
  input  wire logic        start_i,
  input  wire logic        status_clr_i,
  output logic [1:0]       warn_status_o,
  output logic             alert_output_n_o,
  output logic             ramp_en_o
);

  logic [15:0] ov_thresh_reg, ov_thresh_next;
  logic [15:0] uv_thresh_reg, uv_thresh_next;
  logic [15:0] ton_reg,       ton_next;
  logic [15:0] rdata_reg,     rdata_next;
  logic [1:0]  flags_reg,     flags_next;
  logic [20:0] ov_mv, uv_mv; // wide enough for code 4095 at 500 mV without wrapping
  logic        ov_hit, uv_hit;

  // thresholds scaled to millivolts: 500 = 512-8-4, 250 = 256-4-2
  assign ov_mv  = ({9'h000, ov_thresh_reg[11:0]} << 9) - ({9'h000, ov_thresh_reg[11:0]} << 3)
                - ({9'h000, ov_thresh_reg[11:0]} << 2);
  assign uv_mv  = ({9'h000, uv_thresh_reg[11:0]} << 8) - ({9'h000, uv_thresh_reg[11:0]} << 2)
                - ({9'h000, uv_thresh_reg[11:0]} << 1);
  assign ov_hit = {5'h00, vin_mv_i} > ov_mv;
  assign uv_hit = {5'h00, vin_mv_i} < uv_mv;

  // register writes, readback and sticky flags; a new event beats a clear
  always_comb begin
    ov_thresh_next = ov_thresh_reg;
    uv_thresh_next = uv_thresh_reg;
    ton_next       = ton_reg;
    rdata_next     = rdata_reg;
    flags_next     = status_clr_i ? 2'h0 : flags_reg;
    if (ov_hit) flags_next[IVW_ST_OV_BIT] = 1'b1;
    if (uv_hit) flags_next[IVW_ST_UV_BIT] = 1'b1;
    if (req_i.wr) begin
      case (req_i.cmd)
        IVW_CMD_OV_THRESH: ov_thresh_next = req_i.wdata & IVW_THRESH_MASK;
        IVW_CMD_UV_THRESH: uv_thresh_next = req_i.wdata & IVW_THRESH_MASK;
        IVW_CMD_TURN_ON_DELAY_TIME: ton_next       = req_i.wdata;
        default:           ;
      endcase
    end
    if (req_i.rd) begin
      case (req_i.cmd)
        IVW_CMD_OV_THRESH: rdata_next = ov_thresh_reg;
        IVW_CMD_UV_THRESH: rdata_next = uv_thresh_reg;
        IVW_CMD_TURN_ON_DELAY_TIME: rdata_next = ton_reg;
        default:           rdata_next = 16'h0000; // unknown command reads zero
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ov_thresh_reg <= IVW_OV_RESET;
      uv_thresh_reg <= IVW_UV_RESET;
      ton_reg       <= IVW_TON_RESET;
      rdata_reg     <= 16'h0000;
      flags_reg     <= 2'h0;
    end else begin
      ov_thresh_reg <= ov_thresh_next;
      uv_thresh_reg <= uv_thresh_next;
      ton_reg       <= ton_next;
      rdata_reg     <= rdata_next;
      flags_reg     <= flags_next;
    end
  end

  assign rdata_o          = rdata_reg;
  assign warn_status_o    = flags_reg;
  assign alert_output_n_o = ~(|flags_reg); // alert held low while any warning stands

  // turn-on delay: a 1 ms tick divider and a millisecond counter
  ivw_state_t  state_reg, state_next;
  logic [16:0] tick_reg,  tick_next;
  logic [15:0] ms_reg,    ms_next;
  logic        ms_tick;

  assign ms_tick = (tick_reg == 17'(IVW_MS_CYCLES - 1));

  always_comb begin
    state_next = state_reg;
    tick_next  = tick_reg;
    ms_next    = ms_reg;
    case (state_reg)
      IVW_IDLE: begin
        tick_next = 17'h00000;
        ms_next   = 16'h0000;
        if (start_i) state_next = (ton_reg == 16'h0000) ? IVW_RAMP : IVW_WAIT;
      end
      IVW_WAIT: begin
        tick_next = ms_tick ? 17'h00000 : tick_reg + 17'h00001;
        if (!start_i) begin
          state_next = IVW_IDLE; // start withdrawn: abandon the delay
        end else if (ms_tick) begin
          ms_next = ms_reg + 16'h0001;
          if (ms_reg + 16'h0001 >= ton_reg) state_next = IVW_RAMP;
        end
      end
      IVW_RAMP: begin
        if (!start_i) state_next = IVW_IDLE;
      end
      default: state_next = IVW_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= IVW_IDLE;
      tick_reg  <= 17'h00000;
      ms_reg    <= 16'h0000;
    end else begin
      state_reg <= state_next;
      tick_reg  <= tick_next;
      ms_reg    <= ms_next;
    end
  end

  assign ramp_en_o = (state_reg == IVW_RAMP);

  // checks
  ov_flag_set_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ov_hit |=> flags_reg[IVW_ST_OV_BIT]) else $error("ov flag not set");
  uv_flag_set_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    uv_hit |=> flags_reg[IVW_ST_UV_BIT]) else $error("uv flag not set");
  alert_tie_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (ov_hit || uv_hit) |=> !alert_output_n_o) else $error("alert not low after warning");
  thresh_top_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (ov_thresh_reg[15:12] == 4'h0) && (uv_thresh_reg[15:12] == 4'h0)) else $error("top bits set");
  ov_write_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    req_i.wr && req_i.cmd == IVW_CMD_OV_THRESH |=> ov_thresh_reg == ($past(req_i.wdata) & IVW_THRESH_MASK))
    else $error("ov write lost");
  ov_scale_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ov_mv == 21'(ov_thresh_reg[11:0] * IVW_OV_LSB_MV)) else $error("ov scale wrong");
  uv_scale_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    uv_mv == 21'(uv_thresh_reg[11:0] * IVW_UV_LSB_MV)) else $error("uv scale wrong");
  ramp_zero_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    state_reg == IVW_IDLE && start_i && ton_reg == 16'h0000 |=> ramp_en_o) else $error("no ramp");
  ramp_early_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    state_reg == IVW_IDLE && start_i && ton_reg != 16'h0000 |=> !ramp_en_o [*2]) else $error("ramp early");

  // the event has usually passed when alert falls, so look at the flag it left
  ov_seen_c:   cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $fell(alert_output_n_o) && flags_reg[IVW_ST_OV_BIT]);
  uv_seen_c:   cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $fell(alert_output_n_o) && flags_reg[IVW_ST_UV_BIT]);
  ramp_seen_c: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) $rose(ramp_en_o) && ton_reg != 16'h0000);

endmodule // ivw_core

`default_nettype wire

/* File: verilog/ivw_pkg.sv */
// ivw_pkg: command codes, field layouts, reset values and timing counts
// for the input-voltage warning threshold and turn-on delay block.
// assumes a 100 MHz system clock and a command port decoded upstream.
package ivw_pkg;

  // command codes of the three registers
  localparam logic [7:0]  IVW_CMD_OV_THRESH   = 8'h57;
  localparam logic [7:0]  IVW_CMD_UV_THRESH   = 8'h58;
  localparam logic [7:0]  IVW_CMD_TURN_ON_DELAY_TIME   = 8'h60;

  // threshold layout: low 12 bits writable, top 4 read as zero
  localparam int          IVW_THRESH_W        = 12;
  localparam logic [15:0] IVW_THRESH_MASK     = 16'h0FFF;

  // reset values: 0x20 * 0.5 V = 16 V, 0x1C * 0.25 V = 7 V
  localparam logic [15:0] IVW_OV_RESET        = 16'h0020;
  localparam logic [15:0] IVW_UV_RESET        = 16'h001C;
  localparam logic [15:0] IVW_TON_RESET       = 16'h0000;

  // scaling of each threshold code, in millivolts per bit
  localparam int          IVW_OV_LSB_MV       = 500;
  localparam int          IVW_UV_LSB_MV       = 250;

  // turn-on delay counted in milliseconds
  localparam int          IVW_CLK_HZ          = 100_000_000;
  localparam int          IVW_MS_TIME         = 1;
  localparam int          IVW_MS_CYCLES       = IVW_CLK_HZ / 1000 * IVW_MS_TIME;

  // status flag positions in the warning status word
  localparam int          IVW_ST_OV_BIT       = 0;
  localparam int          IVW_ST_UV_BIT       = 1;

  // register access request from the command decoder
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  cmd;
    logic [15:0] wdata;
  } ivw_req_t;

  // start sequencer states
  typedef enum logic [1:0] {
    IVW_IDLE = 2'b00,
    IVW_WAIT = 2'b01,
    IVW_RAMP = 2'b10
  } ivw_state_t;

endpackage

/* File: testbench/ivw_host_model.sv */
// ivw_host_model: command-port host issuing single writes and reads
// assumes tasks are called 1 ns after a rising edge of clk_sys_i
`timescale 1ns/10ps
`default_nettype none
module ivw_host_model
  import ivw_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic [15:0] rdata_i,
  output var  ivw_req_t    req_o
);
  initial req_o = '0;
  // one-cycle write pulse, held until the taking edge
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk_sys_i);
    #1 req_o = '{wr: 1'b1, rd: 1'b0, cmd: c, wdata: d};
    @(posedge clk_sys_i);
    #1 req_o = '0;
  endtask
  // read pulse; data is taken one edge after the request edge
  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    @(posedge clk_sys_i);
    #1 req_o = '{wr: 1'b0, rd: 1'b1, cmd: c, wdata: 16'h0000};
    @(posedge clk_sys_i);
    #1 req_o = '0;
    @(posedge clk_sys_i);
    #1 d = rdata_i;
  endtask
endmodule // ivw_host_model
`default_nettype wire

/* File: testbench/ivw_core_tb.sv */
// ivw_core_tb: self-checking bench, integer model of registers and flags
// assumes ivw_host_model drives the command port at 100 MHz
`timescale 1ns/10ps
`default_nettype none
module ivw_core_tb
  import ivw_pkg::*;
;
  logic        clk_sys_i = 1'b0, rst_n_i = 1'b0, start_i = 1'b0, status_clr_i = 1'b0;
  logic [15:0] vin_mv_i = 16'h2EE0, rdata_o, rd_v;
  logic [1:0]  warn_status_o;
  logic        alert_output_n_o, ramp_en_o;
  ivw_req_t    req_i;
  int          errors = 0, n_compared = 0, cyc = 0, ov_m, uv_m, ton_m, n;
  int          vs[6] = '{16001, 16000, 7249, 7250, 0, 19999};
  // free-running 100 MHz clock
  always #5 clk_sys_i = ~clk_sys_i;
  ivw_core ivw_core_inst (.clk_sys_i, .rst_n_i, .req_i, .rdata_o, .vin_mv_i, .start_i,
    .status_clr_i, .warn_status_o, .alert_output_n_o, .ramp_en_o);
  ivw_host_model ivw_host_model_inst (.clk_sys_i, .rdata_i(rdata_o), .req_o(req_i));
  task automatic tick(int k);
    repeat (k) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // write through the host and mirror it; upper threshold bits are dropped
  task automatic w(logic [7:0] c, logic [15:0] d);
    ivw_host_model_inst.wr(c, d);
    if (c == IVW_CMD_OV_THRESH) ov_m = d & IVW_THRESH_MASK;
    if (c == IVW_CMD_UV_THRESH) uv_m = d & IVW_THRESH_MASK;
    if (c == IVW_CMD_TURN_ON_DELAY_TIME) ton_m = d;
  endtask
  task automatic r(logic [7:0] c, int e);
    ivw_host_model_inst.rd(c, rd_v);
    chk("rdata", e, rd_v);
  endtask
  // one-cycle excursion; flags must still stand after vin returns
  task automatic ex(int v);
    logic [1:0] e;
    e = {1'(v < uv_m * 250), 1'(v > ov_m * 500)};
    vin_mv_i = 16'(v);
    tick(1);
    vin_mv_i = 16'h2EE0;
    tick(2);
    chk("warn", e, warn_status_o);
    chk("alert", ~|e, alert_output_n_o);
    status_clr_i = 1'b1;
    tick(1);
    status_clr_i = 1'b0;
    tick(1);
    chk("warn_clr", 0, warn_status_o);
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard, a little above the longest expected run
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 110000) begin
      errors++;
      tally_and_finish;
    end
  end
  // main sequence
  initial begin
    void'($urandom(44));
    tick(20);
    rst_n_i = 1'b1;
    ov_m = 32;
    uv_m = 28;
    ton_m = 0;
    r(IVW_CMD_OV_THRESH, 32);
    r(IVW_CMD_UV_THRESH, 28);
    r(IVW_CMD_TURN_ON_DELAY_TIME, 0);
    w(8'h59, 16'hFFFF);
    r(8'h59, 0);
    $display("reset values done");
    // host keeps ov in 12..16 V and uv above 7 V, so idle vin of 12 V trips neither
    for (int i = 0; i < 8; i++) begin
      w(IVW_CMD_OV_THRESH, 16'($urandom % 9 + 24) | (16'($urandom) & 16'hF000));
      w(IVW_CMD_UV_THRESH, 16'($urandom % 19 + 29) | (16'($urandom) & 16'hF000));
      r(IVW_CMD_OV_THRESH, ov_m);
      r(IVW_CMD_UV_THRESH, uv_m);
      ex(int'($urandom % 20000));
    end
    $display("threshold access done");
    w(IVW_CMD_OV_THRESH, 16'h0020);
    w(IVW_CMD_UV_THRESH, 16'h001D);
    foreach (vs[i]) ex(vs[i]);
    $display("warning bounds done");
    for (int t = 0; t < 2; t++) begin
      w(IVW_CMD_TURN_ON_DELAY_TIME, 16'(t));
      start_i = 1'b1;
      n = 0;
      while (ramp_en_o !== 1'b1 && n < 100010) begin
        tick(1);
        n++;
      end
      chk("ramp_delay", ton_m * 100000 + 1, n);
      start_i = 1'b0;
      tick(2);
      chk("ramp_off", 0, ramp_en_o);
    end
    $display("turn-on delay done");
    tally_and_finish;
  end
endmodule // ivw_core_tb
`default_nettype wire
